//--- tdh_defines.svh
// Purpose: Offsets, field positions, codes and counts for the slot host
//          channel and synchronous transfer block.
// Assumes: One ref_clk cycle stands for one receive clock period.
// Notes:   Definitions only.
`ifndef TDH_DEFINES_SVH
`define TDH_DEFINES_SVH

// ----------------------------------------
// Device register offsets (4-bit index)
// ----------------------------------------
`define TDH_REG_MEM_DATA    4'h0
`define TDH_REG_MEM_ADDR    4'h1
`define TDH_REG_MEM_CMD     4'h2
`define TDH_REG_STATUS      4'h3
`define TDH_REG_RX_ADDR_A   4'h4
`define TDH_REG_RX_ADDR_B   4'h5
`define TDH_REG_TX_ADDR_A   4'h6
`define TDH_REG_TX_ADDR_B   4'h7
`define TDH_REG_SYNC_CTRL   4'h8
`define TDH_REG_INT_STATUS  4'h9
`define TDH_REG_SYNC_DATA_A 4'ha
`define TDH_REG_SYNC_DATA_B 4'hb

// ----------------------------------------
// Memory commands and codes
// ----------------------------------------
`define TDH_CMD_CREATE      8'h79
`define TDH_CMD_DATA_WR     8'h48
`define TDH_CMD_DATA_RD     8'hc8
`define TDH_CMD_CODE_RD     8'hf0
`define TDH_CMD_CANCEL      8'h70
`define TDH_CODE_HOST       4'h9
`define TDH_CODE_NONE       4'h0
`define TDH_IDLE_BYTE       8'hff
`define TDH_MEM_BUSY_CYCLES 2'h2

// ----------------------------------------
// Field positions
// ----------------------------------------
`define TDH_CTRL_EN_A       6
`define TDH_CTRL_EN_B       7
`define TDH_INT_WIN         1
`define TDH_INT_OVR         0
`define TDH_ADDR_IF         7
`define TDH_CT_FULL         3'h1

// ----------------------------------------
// Window timing in receive clock periods
// ----------------------------------------
`define TDH_CLOSED_PER_CH   6'h10
`define TDH_CLOSED_EXTRA    6'h01
`define TDH_FCNT_MAX        6'h3f

// ----------------------------------------
// Host APB offsets
// ----------------------------------------
`define TDH_APB_CMD         12'h000
`define TDH_APB_STATUS      12'h004
`define TDH_APB_GO_WR       16
`define TDH_APB_GO_RD       17
`endif

//--- tdh_pkg.sv
// Purpose: Types shared by both ends.
// Assumes: Nothing.
// Notes:   Constants live in tdh_defines.svh.
package tdh_pkg;
    typedef enum logic [1:0] {HST_IDLE, HST_STROBE, HST_WAIT} tdh_host_state_t;
    typedef logic [7:0] tdh_byte_t;
endpackage

//--- tdh_bus_if.sv
// Purpose: Parallel register bus between host and device.
// Assumes: Strobes are one-cycle pulses on ref_clk.
// Notes:   Read data is valid the cycle after the read strobe.
`timescale 1ns/1ns
interface tdh_bus_if;
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
    logic [7:0] rdata;
    logic       irq;
    modport dev  (input addr, input wdata, input wr, input rd, output rdata, output irq);
    modport host (output addr, output wdata, output wr, output rd, input rdata, input irq);
endinterface

//--- tdh_device.sv
// Purpose: Slot host channels and two-channel synchronous transfer.
// Assumes: One ref_clk cycle per receive clock period; frame_start marks frame.
// Notes:   Closed phase does sync store then load, one channel per cycle.
// Contract
// - Code 1001 slot exchanges with data field
// - Host channels only whole eight-bit slots
// - Downstream host channel repeats stored byte
// - Upstream host channel data overwritten each frame
// - Host creates with 79, updates with 48
// - C8 reads data field after busy clears
// - F0 returns slot code in low bits
// - Host cancels with 70, code 0000
// - Two independent sync channels A and B
// - Load from rx address, store to tx
// - Control enables channels, selects PCM subslot
// - Host avoids conflicting upstream PCM connection
// - Sync write overwrites any idle code
// - Host sets code 1001 before CONFIGURABLE_INTERFACE sync
// - CONFIGURABLE_INTERFACE sync transfers only full bandwidth
// - Window interrupt when access window opens
// - Overrun if enabled channel not accessed
// - Untouched data resends last received byte
// - Interrupts at fixed frame points
// - Closed 16 periods per channel plus one
// - Data bit 7 is first serial bit
// - Reading interrupt status clears both flags
// - Enable bit 1 enables, 0 disables
`timescale 1ns/1ns
`include "tdh_defines.svh"
module tdh_device
    import tdh_pkg::*;
(
    // Clock and reset
    input  wire logic       ref_clk,
    input  wire logic       rst_n,
    // Register bus
    tdh_bus_if.dev          bus,
    // Serial frame side
    input  wire logic       frame_start,
    input  wire logic       slot_strobe,
    input  wire logic       slot_cfi,
    input  wire logic [6:0] slot_num,
    input  wire logic [7:0] rx_byte,
    output logic      [7:0] tx_byte,
    output logic            tx_valid
);
    // ----------------------------------------
    // State
    // ----------------------------------------
    tdh_byte_t  mem_access_data;
    tdh_byte_t  mem_access_address;
    tdh_byte_t  mem_access_command;
    logic       mem_access_busy;
    logic [1:0] busy_cnt;
    tdh_byte_t  rx_addr [2];
    tdh_byte_t  tx_addr [2];
    tdh_byte_t  sync_control;
    tdh_byte_t  sync_data [2];
    logic [1:0] accessed;
    logic       win_flag;
    logic       ovr_flag;
    logic       win_open;
    logic [5:0] fcnt;
    tdh_byte_t  dm_rx [128];
    tdh_byte_t  dm_tx [128];
    tdh_byte_t  cm_data [256];
    logic [3:0] cm_code [256];
    tdh_byte_t  rdata_q;
    logic       irq_q;

    // Bit 7 of the slot byte is the first serial bit; no reordering here
    function automatic tdh_byte_t sub_mask(input logic [2:0] ct);
        case (ct)
            3'h1:    sub_mask = 8'h0_0ff;
            3'h2:    sub_mask = 8'h0_00f;
            3'h3:    sub_mask = 8'h0_0f0;
            3'h4:    sub_mask = 8'h0_003;
            3'h5:    sub_mask = 8'h0_00c;
            3'h6:    sub_mask = 8'h0_030;
            3'h7:    sub_mask = 8'h0_0c0;
            default: sub_mask = 8'h0_000;
        endcase
    endfunction

    // ----------------------------------------
    // Decode
    // ----------------------------------------
    wire [1:0] ch_en = {sync_control[`TDH_CTRL_EN_B], sync_control[`TDH_CTRL_EN_A]};
    wire [5:0] n_active = {5'h00, ch_en[0]} + {5'h00, ch_en[1]};
    wire [5:0] open_at = 6'((n_active * `TDH_CLOSED_PER_CH) + `TDH_CLOSED_EXTRA);
    wire       wr_hit = bus.wr;
    wire       rd_interrupt_status = bus.rd && (bus.addr == `TDH_REG_INT_STATUS);
    wire       std_a_hit = (bus.addr == `TDH_REG_SYNC_DATA_A) && (bus.wr || bus.rd);
    wire       std_b_hit = (bus.addr == `TDH_REG_SYNC_DATA_B) && (bus.wr || bus.rd);
    wire       cmd_wr = wr_hit && (bus.addr == `TDH_REG_MEM_CMD) && !mem_access_busy;
    wire       cmd_done = mem_access_busy && (busy_cnt == 2'h1);

    // Sync transfer of the current closed-phase cycle: A at 1, B at 2
    wire       xc = (fcnt == 6'h02);
    wire       xfer_go = ((fcnt == 6'h01) && ch_en[0]) || ((fcnt == 6'h02) && ch_en[1]);
    wire [7:0] src = rx_addr[xc];
    wire [7:0] dst = tx_addr[xc];
    wire       cfi_used = src[`TDH_ADDR_IF] || dst[`TDH_ADDR_IF];
    wire [2:0] ct = xc ? sync_control[5:3] : sync_control[2:0];
    // CONFIGURABLE_INTERFACE side takes only the full slot; other widths move nothing
    wire [7:0] msk = (cfi_used && ct != `TDH_CT_FULL) ? 8'h0_000 : sub_mask(ct);
    wire [7:0] src_byte = src[`TDH_ADDR_IF] ? cm_data[{1'b1, src[6:0]}] : dm_rx[src[6:0]];
    wire [7:0] dst_old = dst[`TDH_ADDR_IF] ? cm_data[{1'b0, dst[6:0]}] : dm_tx[dst[6:0]];
    wire [7:0] st_byte = (dst_old & ~msk) | (sync_data[xc] & msk);
    wire [7:0] next_std = (sync_data[xc] & ~msk) | (src_byte & msk);

    // Serial slot lookups: upstream CONFIGURABLE_INTERFACE entries sit at index bit 7 set
    wire [7:0] up_idx = {1'b1, slot_num};
    wire [7:0] dn_idx = {1'b0, slot_num};
    wire       up_host = (cm_code[up_idx] == `TDH_CODE_HOST);
    wire       dn_host = (cm_code[dn_idx] == `TDH_CODE_HOST);

    // Window events at fixed counts from frame start
    wire       set_win = (fcnt == open_at) && !win_open && (ch_en != 2'b00);
    wire       set_ovr = frame_start && win_open && ((ch_en & ~accessed) != 2'b00);

    wire [7:0] next_rdata =
        (bus.addr == `TDH_REG_MEM_DATA)    ? mem_access_data :
        (bus.addr == `TDH_REG_MEM_ADDR)    ? mem_access_address :
        (bus.addr == `TDH_REG_MEM_CMD)     ? mem_access_command :
        (bus.addr == `TDH_REG_STATUS)      ? {7'h00, mem_access_busy} :
        (bus.addr == `TDH_REG_RX_ADDR_A)   ? rx_addr[0] :
        (bus.addr == `TDH_REG_RX_ADDR_B)   ? rx_addr[1] :
        (bus.addr == `TDH_REG_TX_ADDR_A)   ? tx_addr[0] :
        (bus.addr == `TDH_REG_TX_ADDR_B)   ? tx_addr[1] :
        (bus.addr == `TDH_REG_SYNC_CTRL)   ? sync_control :
        (bus.addr == `TDH_REG_INT_STATUS)  ? {6'h00, win_flag, ovr_flag} :
        (bus.addr == `TDH_REG_SYNC_DATA_A) ? sync_data[0] :
        (bus.addr == `TDH_REG_SYNC_DATA_B) ? sync_data[1] : 8'h0_000;

    assign bus.rdata = rdata_q;
    assign bus.irq   = irq_q;

    // ----------------------------------------
    // Register bus and window control
    // ----------------------------------------
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            mem_access_data    <= 8'h0_000;
            mem_access_address <= 8'h0_000;
            mem_access_command <= 8'h0_000;
            rx_addr[0]         <= 8'h0_000;
            rx_addr[1]         <= 8'h0_000;
            tx_addr[0]         <= 8'h0_000;
            tx_addr[1]         <= 8'h0_000;
            sync_control       <= 8'h0_000;
            sync_data[0]       <= 8'h0_000;
            sync_data[1]       <= 8'h0_000;
            rdata_q            <= 8'h0_000;
        end else begin
            if (bus.rd) begin
                rdata_q <= next_rdata;
            end
            if (wr_hit) begin
                case (bus.addr)
                    `TDH_REG_MEM_DATA:  mem_access_data <= bus.wdata;
                    `TDH_REG_MEM_ADDR:  mem_access_address <= bus.wdata;
                    `TDH_REG_RX_ADDR_A: rx_addr[0] <= bus.wdata;
                    `TDH_REG_RX_ADDR_B: rx_addr[1] <= bus.wdata;
                    `TDH_REG_TX_ADDR_A: tx_addr[0] <= bus.wdata;
                    `TDH_REG_TX_ADDR_B: tx_addr[1] <= bus.wdata;
                    `TDH_REG_SYNC_CTRL: sync_control <= bus.wdata;
                    default: ;
                endcase
            end
            if (cmd_wr) begin
                mem_access_command <= bus.wdata;
            end
            // Host writes to the data registers take effect only while the window is open; reads are not gated
            if (win_open && wr_hit && bus.addr == `TDH_REG_SYNC_DATA_A) begin
                sync_data[0] <= bus.wdata;
            end
            if (win_open && wr_hit && bus.addr == `TDH_REG_SYNC_DATA_B) begin
                sync_data[1] <= bus.wdata;
            end
            if (xfer_go) begin
                sync_data[xc] <= next_std;
            end
            if (cmd_done && mem_access_command == `TDH_CMD_DATA_RD) begin
                mem_access_data <= cm_data[mem_access_address];
            end
            if (cmd_done && mem_access_command == `TDH_CMD_CODE_RD) begin
                mem_access_data <= {4'h0, cm_code[mem_access_address]};
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            mem_access_busy <= 1'b0;
            busy_cnt        <= 2'h0;
            win_flag        <= 1'b0;
            ovr_flag        <= 1'b0;
            win_open        <= 1'b0;
            accessed        <= 2'b00;
            fcnt            <= `TDH_FCNT_MAX;
            irq_q           <= 1'b0;
        end else begin
            if (cmd_wr) begin
                mem_access_busy <= 1'b1;
                busy_cnt        <= `TDH_MEM_BUSY_CYCLES;
            end else if (mem_access_busy) begin
                mem_access_busy <= !cmd_done;
                busy_cnt        <= busy_cnt - 2'h1;
            end
            // A new event wins over the clearing read
            win_flag <= set_win || (win_flag && !rd_interrupt_status);
            ovr_flag <= set_ovr || (ovr_flag && !rd_interrupt_status);
            irq_q    <= win_flag || ovr_flag;
            if (frame_start) begin
                fcnt     <= 6'h01;
                win_open <= 1'b0;
            end else if (fcnt != `TDH_FCNT_MAX) begin
                fcnt <= fcnt + 6'h01;
            end
            if (set_win) begin
                win_open <= 1'b1;
                accessed <= 2'b00;
            end else if (win_open) begin
                accessed <= accessed | {std_b_hit, std_a_hit};
            end
        end
    end

    // ----------------------------------------
    // Memories and serial slots
    // ----------------------------------------
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            tx_byte  <= `TDH_IDLE_BYTE;
            tx_valid <= 1'b0;
            for (int i = 0; i < 256; i++) begin
                cm_code[i] <= `TDH_CODE_NONE;
            end
        end else begin
            tx_valid <= slot_strobe;
            if (slot_strobe && slot_cfi) begin
                // Whole slot only: no subslot mask on this side
                if (up_host) begin
                    cm_data[up_idx] <= rx_byte;
                end
                tx_byte <= dn_host ? cm_data[dn_idx] : `TDH_IDLE_BYTE;
            end else if (slot_strobe) begin
                dm_rx[slot_num] <= rx_byte;
                tx_byte         <= dm_tx[slot_num];
            end
            // Store replaces the old value only in the masked bits; bits outside the mask keep it
            if (xfer_go && dst[`TDH_ADDR_IF]) begin
                cm_data[{1'b0, dst[6:0]}] <= st_byte;
            end else if (xfer_go) begin
                dm_tx[dst[6:0]] <= st_byte;
            end
            if (cmd_done) begin
                case (mem_access_command)
                    `TDH_CMD_CREATE: begin
                        cm_data[mem_access_address] <= mem_access_data;
                        cm_code[mem_access_address] <= `TDH_CODE_HOST;
                    end
                    `TDH_CMD_DATA_WR: cm_data[mem_access_address] <= mem_access_data;
                    `TDH_CMD_CANCEL:  cm_code[mem_access_address] <= `TDH_CODE_NONE;
                    default: ;
                endcase
            end
        end
    end
endmodule

//--- tdh_host.sv
// Purpose: Host end: turns APB orders into register bus cycles.
// Assumes: Software sequences commands and polls the busy bit.
// Notes:   One bus cycle outstanding at a time; orders while busy are dropped.
`timescale 1ns/1ns
`include "tdh_defines.svh"
module tdh_host
    import tdh_pkg::*;
(
    // Clock and reset
    input  wire logic        ref_clk,
    input  wire logic        rst_n,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Register bus
    tdh_bus_if.host          bus
);
    // ----------------------------------------
    // State
    // ----------------------------------------
    tdh_host_state_t state;
    logic [3:0]      addr_q;
    tdh_byte_t       wdata_q;
    logic            wr_q;
    logic            rd_q;
    logic            is_rd;
    tdh_byte_t       last_rdata;

    wire setup   = psel && !penable;
    // Order is taken at the completing access edge, not at setup
    wire cmd_hit = psel && penable && pready && pwrite && (paddr == `TDH_APB_CMD);
    wire go      = cmd_hit && (state == HST_IDLE);
    wire go_rd   = pwdata[`TDH_APB_GO_RD];
    wire go_wr   = pwdata[`TDH_APB_GO_WR] && !go_rd;
    wire [31:0] status_word = {15'h0000, bus.irq, last_rdata, 7'h00, state != HST_IDLE};
    wire [31:0] next_prdata = (paddr == `TDH_APB_STATUS) ? status_word : 32'h0000_0000;

    assign bus.addr  = addr_q;
    assign bus.wdata = wdata_q;
    assign bus.wr    = wr_q;
    assign bus.rd    = rd_q;

    // ----------------------------------------
    // APB answer: one wait-free access phase
    // ----------------------------------------
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= setup;
            pslverr <= 1'b0;
            if (setup && !pwrite) begin
                prdata <= next_prdata;
            end
        end
    end

    // ----------------------------------------
    // Bus cycle sequencer
    // ----------------------------------------
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            state      <= HST_IDLE;
            addr_q     <= 4'h0;
            wdata_q    <= 8'h0_000;
            wr_q       <= 1'b0;
            rd_q       <= 1'b0;
            is_rd      <= 1'b0;
            last_rdata <= 8'h0_000;
        end else begin
            case (state)
                HST_IDLE: begin
                    if (go && (go_rd || go_wr)) begin
                        // Command bytes and busy polling come from software
                        addr_q  <= pwdata[3:0];
                        wdata_q <= pwdata[15:8];
                        wr_q    <= go_wr;
                        rd_q    <= go_rd;
                        is_rd   <= go_rd;
                        state   <= HST_STROBE;
                    end
                end
                HST_STROBE: begin
                    wr_q  <= 1'b0;
                    rd_q  <= 1'b0;
                    state <= is_rd ? HST_WAIT : HST_IDLE;
                end
                HST_WAIT: begin
                    last_rdata <= bus.rdata;
                    state      <= HST_IDLE;
                end
                default: state <= HST_IDLE;
            endcase
        end
    end
endmodule

//--- tdh_assertions.sv
// Purpose: Concurrent checks on the register bus and the serial strobes.
// Assumes: Frames are pulsed by the bench; flags are only set near frame points.
// Notes:   Instantiated beside the bus interface in the bench top, no bind.
`timescale 1ns/1ns
`include "tdh_defines.svh"
module tdh_assertions (
    // Clock and reset
    input wire logic       ref_clk,
    input wire logic       rst_n,
    // Register bus
    input wire logic [3:0] addr,
    input wire logic       wr,
    input wire logic       rd,
    input wire logic [7:0] rdata,
    input wire logic       irq,
    // Serial frame side
    input wire logic       frame_start,
    input wire logic       slot_strobe,
    input wire logic       tx_valid
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    // ----------------------------------------
    // Helper counters
    // ----------------------------------------
    logic [7:0] since;
    logic [3:0] cmd_age;
    // Quiet spans keep clear of both flag set points, so a read-clear must stick
    wire logic  quiet = (since >= 8'h04 && since <= 8'h0c) || since >= 8'h28;
    always_ff @(posedge ref_clk) begin
        if (!rst_n || frame_start) begin
            since <= 8'h00;
        end else if (since != 8'hff) begin
            since <= since + 8'h01;
        end
    end
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            cmd_age <= 4'hf;
        end else if (wr && addr == `TDH_REG_MEM_CMD) begin
            cmd_age <= 4'h0;
        end else if (cmd_age != 4'hf) begin
            cmd_age <= cmd_age + 4'h1;
        end
    end
    // ----------------------------------------
    // Properties
    // ----------------------------------------
    sequence s_status_rd;
        rd && addr == `TDH_REG_STATUS;
    endsequence
    sequence s_cmd_settled;
        cmd_age >= 4'h2;
    endsequence
    property p_busy_clear;
        s_status_rd ##0 s_cmd_settled |=> !rdata[0];
    endproperty
    property p_tx_follow;
        1'b1 |=> tx_valid == $past(slot_strobe);
    endproperty
    property p_rdata_hold;
        !rd |=> $stable(rdata);
    endproperty
    property p_unmapped_zero;
        rd && addr >= 4'hc |=> rdata == 8'h00;
    endproperty
    property p_interrupt_status_clear;
        rd && addr == `TDH_REG_INT_STATUS && quiet |-> ##2 !irq;
    endproperty
    property p_irq_points;
        $rose(irq) |-> (since >= 8'h01 && since <= 8'h03) || (since >= 8'h10 && since <= 8'h24);
    endproperty
    property p_bus_pulse;
        wr |=> !wr && !rd;
    endproperty
    property p_one_strobe;
        !(wr && rd);
    endproperty
    a_busy_clear: assert property (p_busy_clear) else $error("busy still set");
    a_tx_follow: assert property (p_tx_follow) else $error("tx_valid off strobe");
    a_rdata_hold: assert property (p_rdata_hold) else $error("rdata moved");
    a_unmapped_zero: assert property (p_unmapped_zero) else $error("unmapped read");
    a_interrupt_status_clear: assert property (p_interrupt_status_clear) else $error("flags not cleared");
    a_irq_points: assert property (p_irq_points) else $error("irq off frame point");
    a_bus_pulse: assert property (p_bus_pulse) else $error("strobe too long");
    a_one_strobe: assert property (p_one_strobe) else $error("wr and rd together");
endmodule

//--- tdm_host_channel_sync_transfer_tb_top.sv
// Purpose: Bench for host channels and synchronous transfer, both ends joined.
// Assumes: Host APB answers wait-free; frames are pulsed by the bench.
// Notes:   Random bytes from a fixed seed, boundary slots written by hand.
`timescale 1ns/1ns
`include "tdh_defines.svh"
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin n_mismatch++; \
    $display("Error t=%0t got %h exp %h", $time, g, e); end end
module tdm_host_channel_sync_transfer_tb_top import tdh_pkg::*;;
    logic        ref_clk, rst_n, psel, penable, pwrite, frame_start, slot_strobe, slot_cfi;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rdv;
    logic        pready, pslverr, tx_valid;
    logic [6:0]  slot_num, n;
    tdh_byte_t   rx_byte, tx_byte, v, d, xa, xb, ya, yb;
    int          n_mismatch = 0;
    int          checked = 0;
    tdh_bus_if   bus ();
    tdh_host tdh_host_inst (.ref_clk(ref_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .bus(bus));
    tdh_device tdh_device_inst (.ref_clk(ref_clk), .rst_n(rst_n), .bus(bus),
        .frame_start(frame_start), .slot_strobe(slot_strobe), .slot_cfi(slot_cfi),
        .slot_num(slot_num), .rx_byte(rx_byte), .tx_byte(tx_byte), .tx_valid(tx_valid));
    tdh_assertions tdh_assertions_inst (.ref_clk(ref_clk), .rst_n(rst_n), .addr(bus.addr),
        .wr(bus.wr), .rd(bus.rd), .rdata(bus.rdata), .irq(bus.irq),
        .frame_start(frame_start), .slot_strobe(slot_strobe), .tx_valid(tx_valid));
    // ----------------------------------------
    // Expectations and bus tasks
    // ----------------------------------------
    function automatic tdh_byte_t exp_tx(input logic host, input tdh_byte_t b);
        return host ? b : `TDH_IDLE_BYTE;
    endfunction
    function automatic logic [1:0] exp_interrupt_status(input logic win, input logic ovr);
        return {win, ovr};
    endfunction
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
        @(posedge ref_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge ref_clk);
        penable <= 1'b1;
        // Look mid-cycle so the edge that launches pready is never raced
        do @(negedge ref_clk); while (pready !== 1'b1);
        rdv = prdata;
        @(posedge ref_clk);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // One device register access; waits out the host end's own bus cycle
    task automatic dev(input logic rdn, input logic [3:0] a, input tdh_byte_t wd);
        apb(1'b1, `TDH_APB_CMD, {14'h0000, rdn, !rdn, wd, 4'h0, a});
        rdv = 32'h0000_0001;
        for (int i = 0; i < 20 && rdv[0] !== 1'b0; i++) apb(1'b0, `TDH_APB_STATUS, 32'h0);
        v = rdv[15:8];
    endtask
    task automatic mem(input tdh_byte_t cmd, input tdh_byte_t a, input tdh_byte_t wd);
        dev(1'b0, `TDH_REG_MEM_DATA, wd);
        dev(1'b0, `TDH_REG_MEM_ADDR, a);
        dev(1'b0, `TDH_REG_MEM_CMD, cmd);
        v = 8'h01;
        for (int i = 0; i < 20 && v[0] !== 1'b0; i++) dev(1'b1, `TDH_REG_STATUS, 8'h00);
        dev(1'b1, `TDH_REG_MEM_DATA, 8'h00);
    endtask
    task automatic slot(input logic c, input logic [6:0] sn, input tdh_byte_t rx);
        @(posedge ref_clk);
        slot_strobe <= 1'b1;
        slot_cfi <= c;
        slot_num <= sn;
        rx_byte <= rx;
        @(posedge ref_clk);
        slot_strobe <= 1'b0;
        @(negedge ref_clk);
        `CHK(tx_valid, 1'b1)
        v = tx_byte;
    endtask
    // Waits past the longest closed span so the window is open on return whenever a channel is enabled
    task automatic frame();
        @(posedge ref_clk);
        frame_start <= 1'b1;
        @(posedge ref_clk);
        frame_start <= 1'b0;
        repeat (40) @(posedge ref_clk);
    endtask
    task automatic results();
        $display("Mismatches %0d, comparisons %0d", n_mismatch, checked);
        if (n_mismatch == 0 && checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // ----------------------------------------
    // Clock, watchdog, main sequence
    // ----------------------------------------
    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end
    initial begin
        repeat (20000) @(posedge ref_clk);
        n_mismatch++;
        results();
    end
    initial begin
        {rst_n, psel, penable, pwrite, frame_start, slot_strobe, slot_cfi} = 7'h00;
        {paddr, pwdata, slot_num, rx_byte} = '0;
        void'($urandom(37291));
        repeat (3) @(posedge ref_clk);
        rst_n <= 1'b1;
        for (int k = 0; k < 3; k++) begin
            n = (k == 0) ? 7'h00 : (k == 1) ? 7'h7f : 7'($urandom);
            d = 8'($urandom);
            mem(`TDH_CMD_CREATE, {1'b0, n}, d);
            slot(1'b1, n, 8'h00);
            `CHK(v, exp_tx(1'b1, d))
            slot(1'b1, n, 8'h00);
            `CHK(v, d)
            mem(`TDH_CMD_CODE_RD, {1'b0, n}, 8'h00);
            `CHK(v[3:0], `TDH_CODE_HOST)
            mem(`TDH_CMD_DATA_WR, {1'b0, n}, ~d);
            slot(1'b1, n, 8'h00);
            `CHK(v, ~d)
            mem(`TDH_CMD_DATA_RD, {1'b0, n}, 8'h00);
            `CHK(v, ~d)
            mem(`TDH_CMD_CREATE, {1'b1, n}, 8'h00);
            slot(1'b1, n, d);
            mem(`TDH_CMD_DATA_RD, {1'b1, n}, 8'h00);
            `CHK(v, d)
            slot(1'b1, n, ~d);
            mem(`TDH_CMD_DATA_RD, {1'b1, n}, 8'h00);
            `CHK(v, ~d)
            mem(`TDH_CMD_CANCEL, {1'b0, n}, 8'h00);
            slot(1'b1, n, 8'h00);
            `CHK(v, exp_tx(1'b0, d))
            mem(`TDH_CMD_CODE_RD, {1'b0, n}, 8'h00);
            `CHK(v[3:0], `TDH_CODE_NONE)
        end
        dev(1'b1, 4'hf, 8'h00);
        `CHK(v, 8'h00)
        {xa, xb, ya, yb} = $urandom;
        // PCM slots only, no upstream connection on them
        dev(1'b0, `TDH_REG_RX_ADDR_A, 8'h05);
        dev(1'b0, `TDH_REG_TX_ADDR_A, 8'h09);
        dev(1'b0, `TDH_REG_RX_ADDR_B, 8'h14);
        dev(1'b0, `TDH_REG_TX_ADDR_B, 8'h15);
        dev(1'b0, `TDH_REG_SYNC_CTRL, 8'hc9);
        slot(1'b0, 7'h05, xa);
        slot(1'b0, 7'h14, xb);
        frame();
        dev(1'b1, `TDH_REG_INT_STATUS, 8'h00);
        `CHK(v[1:0], exp_interrupt_status(1'b1, 1'b0))
        dev(1'b1, `TDH_REG_INT_STATUS, 8'h00);
        `CHK(v[1:0], exp_interrupt_status(1'b0, 1'b0))
        dev(1'b1, `TDH_REG_SYNC_DATA_A, 8'h00);
        `CHK(v, xa)
        dev(1'b1, `TDH_REG_SYNC_DATA_B, 8'h00);
        `CHK(v, xb)
        dev(1'b0, `TDH_REG_SYNC_DATA_A, ya);
        dev(1'b0, `TDH_REG_SYNC_DATA_B, yb);
        slot(1'b0, 7'h05, ~xa);
        frame();
        slot(1'b0, 7'h09, 8'h00);
        `CHK(v, ya)
        slot(1'b0, 7'h15, 8'h00);
        `CHK(v, yb)
        frame();
        dev(1'b1, `TDH_REG_INT_STATUS, 8'h00);
        `CHK(v[1:0], exp_interrupt_status(1'b1, 1'b1))
        slot(1'b0, 7'h09, 8'h00);
        `CHK(v, ~xa)
        dev(1'b0, `TDH_REG_SYNC_DATA_A, ya);
        dev(1'b0, `TDH_REG_SYNC_CTRL, 8'h00);
        frame();
        dev(1'b1, `TDH_REG_INT_STATUS, 8'h00);
        `CHK(v[1:0], exp_interrupt_status(1'b0, 1'b0))
        slot(1'b0, 7'h09, 8'h00);
        `CHK(v, ~xa)
        results();
    end
endmodule
